//--- hdl/volume_ramp_pkg.sv
// Constants, register map and decoders for the volume ramp and auto mute.
// Assumes a single clock domain and byte wide registers.
package volume_ramp_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_NORMAL_RAMP = 8'h4e;
  localparam logic [7:0] ADDR_EMERG_RAMP  = 8'h4f;
  localparam logic [7:0] ADDR_ZERO_CTL    = 8'h50;
  localparam logic [7:0] ADDR_ZERO_TIME   = 8'h51;

  // Reset values
  localparam logic [7:0] RST_NORMAL_RAMP  = 8'h33;
  localparam logic [7:0] RST_EMERG_RAMP   = 8'h30;
  localparam logic [7:0] RST_ZERO_CTL     = 8'h07;
  localparam logic [7:0] RST_ZERO_TIME    = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED   = 8'h00;

  // Field positions
  localparam int NORMAL_FALL_RATE_LSB = 6;
  localparam int NORMAL_FALL_STEP_LSB = 4;
  localparam int RISE_RATE_LSB        = 2;
  localparam int RISE_STEP_LSB        = 0;
  localparam int EMERG_RATE_LSB       = 6;
  localparam int EMERG_STEP_LSB       = 4;
  localparam int ZERO_GROUP_BIT       = 2;
  localparam int ZERO_RIGHT_EN_BIT    = 1;
  localparam int ZERO_LEFT_EN_BIT     = 0;
  localparam int LEFT_TIMEOUT_LSB     = 4;
  localparam int RIGHT_TIMEOUT_LSB    = 0;

  // Codes and volume values
  localparam logic [1:0] RATE_INSTANT = 2'h3;
  localparam logic [7:0] STEP_LARGEST = 8'h08;
  localparam logic [7:0] VOL_MUTE     = 8'hff;
  localparam logic [7:0] VOL_RESET    = 8'hff;

  // Zero run timeouts in microseconds at the reference sample rate
  localparam int ZERO_REF_HZ = 96000;
  localparam longint US_PER_S = 1000000;
  localparam int ZERO_TIME_US [8] = '{11500, 53000, 106500, 266500,
                                      535000, 1065000, 2665000, 5330000};
  localparam int ZCNT_W = 20;

  typedef enum logic [1:0] {RAMP_IDLE, RAMP_FALL, RAMP_RISE} ramp_e;

  // Step size in half dB units: 8, 4, 2, 1
  function automatic logic [7:0] step_size(input logic [1:0] code);
    return STEP_LARGEST >> code;
  endfunction

  // Last count of the update interval: 0, 1, 3
  function automatic logic [1:0] rate_last(input logic [1:0] code);
    return 2'((3'h1 << code) - 3'h1);
  endfunction

  // Zero samples needed for a timeout code at a given sample rate
  function automatic logic [ZCNT_W-1:0] zero_limit(input logic [2:0] code,
                                                   input int rate_hz);
    longint v;
    v = longint'(ZERO_TIME_US[code]) * longint'(rate_hz) / US_PER_S;
    if (v < 1)
    begin
      v = 1;
    end
    return ZCNT_W'(v);
  endfunction

endpackage

//--- hdl/sample_stream_if.sv
// Valid and ready stream carrying one stereo sample word.
// Assumes both ends run on the same clock.
interface sample_stream_if #(parameter int WIDTH = 48);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- hdl/sample_fifo.sv
// Small stereo sample FIFO with registered full and empty flags.
// Assumes the reader may stall at any time; ce freezes all state.
module sample_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input logic               clk,
  input logic               rst,
  input logic               ce,
  // Streams
  sample_stream_if.snk      wr,
  sample_stream_if.src      rd
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  logic             has_room;
  logic             has_data;
  logic [AW-1:0]    next_wptr;
  logic [AW-1:0]    next_rptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign push     = wr.valid & has_room;
  assign pop      = rd.ready & has_data;
  assign wr.ready = has_room;
  assign rd.valid = has_data;
  assign rd.data  = mem[rptr];

  always_comb
  begin
    next_wptr  = wptr;
    next_rptr  = rptr;
    next_count = count;
    if (push)
    begin
      next_wptr = (wptr == LAST) ? '0 : AW'(wptr + 1'b1);
    end
    if (pop)
    begin
      next_rptr = (rptr == LAST) ? '0 : AW'(rptr + 1'b1);
    end
    if (push && !pop)
    begin
      next_count = (AW + 1)'(count + 1'b1);
    end
    else if (pop && !push)
    begin
      next_count = (AW + 1)'(count - 1'b1);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wptr     <= '0;
      rptr     <= '0;
      count    <= '0;
      has_room <= 1'b1;
      has_data <= 1'b0;
    end
    else if (ce)
    begin
      wptr     <= next_wptr;
      rptr     <= next_rptr;
      count    <= next_count;
      has_room <= (next_count != FULL);
      has_data <= (next_count != '0);
    end
  end

  always_ff @(posedge clk)
  begin
    if (ce && push)
    begin
      mem[wptr] <= wr.data;
    end
  end

endmodule // sample_fifo

//--- hdl/zero_run.sv
// Counts consecutive zero samples of one channel against a limit.
// Assumes take marks one sample period; ce freezes all state.
module zero_run import volume_ramp_pkg::*; #(
  parameter int CNT_W = ZCNT_W
) (
  // Clock and reset
  input logic             clk,
  input logic             rst,
  input logic             ce,
  // Sample
  input logic             take,
  input logic             is_zero,
  input logic [CNT_W-1:0] limit,
  // Result
  output logic            qualified
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             next_qualified;

  always_comb
  begin
    next_cnt = cnt;
    if (take)
    begin
      if (!is_zero)
      begin
        next_cnt = '0;
      end
      else if (cnt < limit)
      begin
        next_cnt = CNT_W'(cnt + 1'b1);
      end
    end
    next_qualified = (next_cnt >= limit);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt       <= '0;
      qualified <= 1'b0;
    end
    else if (ce)
    begin
      cnt       <= next_cnt;
      qualified <= next_qualified;
    end
  end

endmodule // zero_run

//--- hdl/volume_ramp_auto_mute.sv
// Volume ramp and auto mute control for a stereo sample stream.
// Assumes samples and register port share clk; emergency_req is a pin.
module volume_ramp_auto_mute import volume_ramp_pkg::*; #(
  parameter int SAMPLE_W     = 24,
  parameter int FIFO_DEPTH   = 4,
  parameter int ZERO_RATE_HZ = ZERO_REF_HZ
) (
  // Clock and reset
  input logic                 clk,
  input logic                 rst,
  input logic                 ce,
  // Register port
  input logic [7:0]           reg_addr,
  input logic [7:0]           reg_wdata,
  input logic                 reg_wr,
  input logic                 reg_rd,
  output logic [7:0]          reg_rdata,
  // Volume target and emergency
  input logic [7:0]           target_volume_code,
  input logic                 emergency_req,
  // Sample input
  input logic                 in_valid,
  output logic                in_ready,
  input logic [SAMPLE_W-1:0]  in_left,
  input logic [SAMPLE_W-1:0]  in_right,
  // Sample output
  output logic                out_valid,
  input logic                 out_ready,
  output logic [SAMPLE_W-1:0] out_left,
  output logic [SAMPLE_W-1:0] out_right,
  output logic [7:0]          out_vol_left,
  output logic [7:0]          out_vol_right,
  // Status
  output logic                am_both,
  output logic                am_left,
  output logic                am_right,
  output logic                ramp_busy
);
  localparam int SW2 = 2 * SAMPLE_W;

  sample_stream_if #(.WIDTH(SW2)) push_s ();
  sample_stream_if #(.WIDTH(SW2)) pop_s ();

  logic [7:0]          normal_volume_ramp_config;
  logic [7:0]          emergency_ramp_config;
  logic [7:0]          zero_mute_control;
  logic [7:0]          zero_mute_timeout;
  logic [7:0]          next_normal_volume_ramp_config;
  logic [7:0]          next_emergency_ramp_config;
  logic [7:0]          next_zero_mute_control;
  logic [7:0]          next_zero_mute_timeout;
  logic [7:0]          next_reg_rdata;
  logic                emerg_meta;
  logic                emerg_s;
  logic                take;
  logic [SAMPLE_W-1:0] smp [2];
  logic [1:0]          qual;
  logic [1:0]          chan_en;
  logic                grouped;
  logic [1:0]          am;
  logic [1:0]          next_am;
  logic [7:0]          vol [2];
  logic [7:0]          next_vol [2];
  logic [1:0]          cnt [2];
  logic [1:0]          next_cnt [2];
  logic [7:0]          dest [2];
  ramp_e               dir [2];
  logic [1:0]          rate_sel [2];
  logic [7:0]          step_sel [2];
  logic                next_out_valid;
  logic                next_busy;

  logic [1:0] normal_fall_rate;
  logic [1:0] normal_fall_step;
  logic [1:0] rise_rate;
  logic [1:0] rise_step;
  logic [1:0] emerg_rate;
  logic [1:0] emerg_step;
  logic [2:0] left_zero_timeout;
  logic [2:0] right_zero_timeout;

  assign normal_fall_rate = normal_volume_ramp_config[NORMAL_FALL_RATE_LSB+:2];
  assign normal_fall_step = normal_volume_ramp_config[NORMAL_FALL_STEP_LSB+:2];
  assign rise_rate        = normal_volume_ramp_config[RISE_RATE_LSB+:2];
  assign rise_step        = normal_volume_ramp_config[RISE_STEP_LSB+:2];
  assign emerg_rate       = emergency_ramp_config[EMERG_RATE_LSB+:2];
  assign emerg_step       = emergency_ramp_config[EMERG_STEP_LSB+:2];
  assign left_zero_timeout  = zero_mute_timeout[LEFT_TIMEOUT_LSB+:3];
  assign right_zero_timeout = zero_mute_timeout[RIGHT_TIMEOUT_LSB+:3];
  assign grouped    = zero_mute_control[ZERO_GROUP_BIT];
  assign chan_en[0] = zero_mute_control[ZERO_LEFT_EN_BIT];
  assign chan_en[1] = zero_mute_control[ZERO_RIGHT_EN_BIT];

  // Input FIFO
  assign push_s.valid = in_valid;
  assign push_s.data  = {in_left, in_right};
  assign in_ready     = push_s.ready;
  assign pop_s.ready  = !out_valid || out_ready;
  assign take         = pop_s.valid && pop_s.ready;
  assign smp[0]       = pop_s.data[SW2-1:SAMPLE_W];
  assign smp[1]       = pop_s.data[SAMPLE_W-1:0];

  sample_fifo #(.WIDTH(SW2), .DEPTH(FIFO_DEPTH)) sample_fifo_inst (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .wr  (push_s),
    .rd  (pop_s)
  );

  // Zero run detectors
  for (genvar g = 0; g < 2; g++)
  begin : g_zero
    zero_run zero_run_inst (
      .clk       (clk),
      .rst       (rst),
      .ce        (ce),
      .take      (take),
      .is_zero   (smp[g] == '0),
      .limit     (zero_limit(g == 0 ? left_zero_timeout
                                    : right_zero_timeout,
                             ZERO_RATE_HZ)),
      .qualified (qual[g])
    );
  end

  // Register port
  always_comb
  begin
    next_normal_volume_ramp_config = normal_volume_ramp_config;
    next_emergency_ramp_config     = emergency_ramp_config;
    next_zero_mute_control         = zero_mute_control;
    next_zero_mute_timeout         = zero_mute_timeout;
    next_reg_rdata                 = reg_rdata;
    if (reg_wr)
    begin
      case (reg_addr)
        ADDR_NORMAL_RAMP: next_normal_volume_ramp_config = reg_wdata;
        ADDR_EMERG_RAMP:  next_emergency_ramp_config     = reg_wdata;
        ADDR_ZERO_CTL:    next_zero_mute_control         = reg_wdata;
        ADDR_ZERO_TIME:   next_zero_mute_timeout         = reg_wdata;
        default:          next_reg_rdata                 = reg_rdata;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_NORMAL_RAMP: next_reg_rdata = normal_volume_ramp_config;
        ADDR_EMERG_RAMP:  next_reg_rdata = emergency_ramp_config;
        ADDR_ZERO_CTL:    next_reg_rdata = zero_mute_control;
        ADDR_ZERO_TIME:   next_reg_rdata = zero_mute_timeout;
        default:          next_reg_rdata = RDATA_UNMAPPED;
      endcase
    end
  end

  // Auto mute decision and volume ramp per channel
  always_comb
  begin
    for (int ch = 0; ch < 2; ch++)
    begin
      next_am[ch] = chan_en[ch] && qual[ch]
                    && (!grouped || qual[1-ch]);
      dest[ch] = (emerg_s || am[ch]) ? VOL_MUTE : target_volume_code;
      if (dest[ch] > vol[ch])
      begin
        dir[ch] = RAMP_FALL;
      end
      else if (dest[ch] < vol[ch])
      begin
        dir[ch] = RAMP_RISE;
      end
      else
      begin
        dir[ch] = RAMP_IDLE;
      end
      if (dir[ch] == RAMP_FALL && emerg_s)
      begin
        rate_sel[ch] = emerg_rate;
        step_sel[ch] = step_size(emerg_step);
      end
      else if (dir[ch] == RAMP_FALL)
      begin
        rate_sel[ch] = normal_fall_rate;
        step_sel[ch] = step_size(normal_fall_step);
      end
      else
      begin
        rate_sel[ch] = rise_rate;
        step_sel[ch] = step_size(rise_step);
      end
      next_vol[ch] = vol[ch];
      next_cnt[ch] = cnt[ch];
      if (take)
      begin
        if (dir[ch] == RAMP_IDLE)
        begin
          next_cnt[ch] = '0;
        end
        else if (rate_sel[ch] == RATE_INSTANT)
        begin
          next_vol[ch] = dest[ch];
          next_cnt[ch] = '0;
        end
        else if (cnt[ch] >= rate_last(rate_sel[ch]))
        begin
          next_cnt[ch] = '0;
          unique case (dir[ch])
            RAMP_FALL:
              next_vol[ch] = (dest[ch] - vol[ch] <= step_sel[ch]) ? dest[ch]
                             : 8'(vol[ch] + step_sel[ch]);
            RAMP_RISE:
              next_vol[ch] = (vol[ch] - dest[ch] <= step_sel[ch]) ? dest[ch]
                             : 8'(vol[ch] - step_sel[ch]);
            RAMP_IDLE:
              next_vol[ch] = vol[ch];
          endcase
        end
        else
        begin
          next_cnt[ch] = 2'(cnt[ch] + 1'b1);
        end
      end
    end
    next_busy      = (dir[0] != RAMP_IDLE) || (dir[1] != RAMP_IDLE);
    next_out_valid = take || (out_valid && !out_ready);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      normal_volume_ramp_config <= RST_NORMAL_RAMP;
      emergency_ramp_config     <= RST_EMERG_RAMP;
      zero_mute_control         <= RST_ZERO_CTL;
      zero_mute_timeout         <= RST_ZERO_TIME;
      reg_rdata                 <= RDATA_UNMAPPED;
      emerg_meta                <= 1'b0;
      emerg_s                   <= 1'b0;
      am                        <= '0;
      vol                       <= '{VOL_RESET, VOL_RESET};
      cnt                       <= '{2'h0, 2'h0};
      out_valid                 <= 1'b0;
      out_left                  <= '0;
      out_right                 <= '0;
      out_vol_left              <= VOL_RESET;
      out_vol_right             <= VOL_RESET;
      am_both                   <= 1'b0;
      am_left                   <= 1'b0;
      am_right                  <= 1'b0;
      ramp_busy                 <= 1'b0;
    end
    else if (ce)
    begin
      normal_volume_ramp_config <= next_normal_volume_ramp_config;
      emergency_ramp_config     <= next_emergency_ramp_config;
      zero_mute_control         <= next_zero_mute_control;
      zero_mute_timeout         <= next_zero_mute_timeout;
      reg_rdata                 <= next_reg_rdata;
      emerg_meta                <= emergency_req;
      emerg_s                   <= emerg_meta;
      am                        <= next_am;
      vol                       <= next_vol;
      cnt                       <= next_cnt;
      out_valid                 <= next_out_valid;
      if (take)
      begin
        out_left      <= smp[0];
        out_right     <= smp[1];
        out_vol_left  <= next_vol[0];
        out_vol_right <= next_vol[1];
      end
      am_both   <= next_am[0] && next_am[1];
      am_left   <= next_am[0];
      am_right  <= next_am[1];
      ramp_busy <= next_busy;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_UPD_ON_SAMPLE:
    assert property (vol[0] != $past(vol[0]) |-> $past(take && ce))
    else $error("Left volume moved without a sample");
  AST_INSTANT_FALL:
    assert property (ce && take && !emerg_s && dir[0] == RAMP_FALL
                     && normal_fall_rate == RATE_INSTANT
                     |=> vol[0] == $past(dest[0]))
    else $error("Instant fall did not reach destination");
  AST_FALL_STEP:
    assert property (ce && take && !emerg_s && dir[0] == RAMP_FALL
                     && normal_fall_rate != RATE_INSTANT
                     && cnt[0] >= rate_last(normal_fall_rate)
                     |=> vol[0] == $past(dest[0]) || vol[0] - $past(vol[0])
                         == step_size($past(normal_fall_step)))
    else $error("Normal fall step size wrong");
  AST_RISE_PACE:
    assert property (ce && take && dir[0] == RAMP_RISE
                     && rise_rate != RATE_INSTANT
                     && cnt[0] < rate_last(rise_rate)
                     |=> vol[0] == $past(vol[0]))
    else $error("Rise stepped before its interval");
  AST_INSTANT_RISE:
    assert property (ce && take && dir[1] == RAMP_RISE
                     && rise_rate == RATE_INSTANT
                     |=> vol[1] == $past(target_volume_code))
    else $error("Instant rise did not restore target");
  AST_RISE_STEP:
    assert property (ce && take && dir[1] == RAMP_RISE
                     && rise_rate != RATE_INSTANT
                     && cnt[1] >= rate_last(rise_rate)
                     |=> vol[1] == $past(dest[1]) || $past(vol[1]) - vol[1]
                         == step_size($past(rise_step)))
    else $error("Rise step size wrong");
  AST_EMERG_MUTE:
    assert property (ce && take && emerg_s && emerg_rate == RATE_INSTANT
                     |=> vol[0] == VOL_MUTE && vol[1] == VOL_MUTE)
    else $error("Emergency instant mute missed");
  AST_LEFT_DISABLED:
    assert property (ce && !chan_en[0] |=> !am_left)
    else $error("Left auto mute while disabled");
  AST_GROUPED:
    assert property (ce && grouped && chan_en == 2'h3 |=> am_left == am_right)
    else $error("Grouped auto mute split channels");
  AST_BOTH_FLAG:
    assert property (ce && chan_en == 2'h3 && qual == 2'h3 |=> am_both)
    else $error("Both flag missing with both channels qualified");
  AST_WAKE:
    assert property (ce && take && smp[0] != '0 ##1 ce |=> !am_left)
    else $error("Nonzero sample did not end left auto mute");

  COV_EMERG: cover property (emerg_s && vol[0] == VOL_MUTE);
  COV_BOTH:  cover property (am_both ##[1:300] !am_both);
  COV_FULL:  cover property (out_valid && !out_ready && !in_ready);

endmodule // volume_ramp_auto_mute

//--- tb/sample_sink.sv
// Downstream sample sink that stalls at random and logs each word.
// Assumes the output handshake of the volume block on one clock.
module sample_sink (
  // Clock and reset
  input logic        clk,
  input logic        rst,
  // Output stream
  input logic        out_valid,
  output logic       out_ready,
  input logic [23:0] out_left,
  input logic [23:0] out_right,
  input logic [7:0]  out_vol_left,
  input logic [7:0]  out_vol_right
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] q[$];
  int          got;
  logic [4:0]  lfsr;

  // Ready low about one cycle in four
  assign out_ready = lfsr[0] | lfsr[2];

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lfsr <= 5'h1f;
      got  <= 0;
    end
    else
    begin
      lfsr <= {lfsr[3:0], lfsr[4] ^ lfsr[2]};
      if (out_valid && out_ready)
      begin
        q.push_back({out_left, out_right, out_vol_left, out_vol_right});
        got <= got + 1;
      end
    end
  end
endmodule // sample_sink

//--- tb/volume_ramp_auto_mute_bench.sv
// Self-checking bench for the volume ramp and auto mute block.
// Assumes the sample sink model drains the output stream.
module volume_ramp_auto_mute_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import volume_ramp_pkg::*;
  logic        clk = 0, rst = 1, ce = 1, reg_wr = 0, reg_rd = 0;
  logic        emergency_req = 0, in_valid = 0;
  logic [7:0]  reg_addr = 0, reg_wdata = 0, target_volume_code = 8'h30;
  logic [23:0] in_left = 0, in_right = 0;
  logic [7:0]  reg_rdata, out_vol_left, out_vol_right, d, e, st;
  logic        in_ready, out_valid, out_ready, am_both, am_left, am_right;
  logic [63:0] v;
  logic [47:0] sq[$];
  logic [23:0] out_left, out_right;
  logic        ramp_busy;
  logic [31:0] seed = 32'h00008c14;
  int          failures = 0, tests_run = 0, sent = 0;
  logic [7:0]  rtab[5] = '{8'h33, 8'h30, 8'h07, 8'h00, 8'h00};
  logic [7:0]  tcfg[8] = '{8'h33, 8'h3f, 8'h90, 8'h04,
                           8'hc0, 8'h3f, 8'h50, 8'h3f};
  logic [7:0]  ttgt[8] = '{8'h30, 8'h30, 8'h50, 8'h20,
                           8'hff, 8'h30, 8'h30, 8'h30};
  int          tn[8] = '{8, 2, 12, 8, 2, 2, 6, 2};
  logic [7:0]  tmg = 8'h40;

  volume_ramp_auto_mute #(.ZERO_RATE_HZ(1000)) volume_ramp_auto_mute_inst (
    .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .target_volume_code(target_volume_code),
    .emergency_req(emergency_req), .in_valid(in_valid),
    .in_ready(in_ready), .in_left(in_left), .in_right(in_right),
    .out_valid(out_valid), .out_ready(out_ready), .out_left(out_left),
    .out_right(out_right), .out_vol_left(out_vol_left),
    .out_vol_right(out_vol_right), .am_both(am_both), .am_left(am_left),
    .am_right(am_right), .ramp_busy(ramp_busy));

  sample_sink sample_sink_inst (
    .clk(clk), .rst(rst), .out_valid(out_valid), .out_ready(out_ready),
    .out_left(out_left), .out_right(out_right),
    .out_vol_left(out_vol_left), .out_vol_right(out_vol_right));

  always #50 clk = ~clk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Volume after k takes from s toward d under config c
  function automatic logic [7:0] expv(logic [7:0] c, dd, s, int k);
    int rt, sp, dv, si, di;
    si = s;
    di = dd;
    rt = (di < si) ? c[3:2] : c[7:6];
    sp = (di < si) ? c[1:0] : c[5:4];
    dv = (k >> rt) * (8 >> sp);
    if (rt == 3) return dd;
    if (di < si) return (si - dv < di) ? dd : 8'(si - dv);
    return (si + dv > di) ? dd : 8'(si + dv);
  endfunction

  task automatic check(logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (failures == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic reg_write(logic [7:0] a, logic [7:0] w);
    reg_addr = a;
    reg_wdata = w;
    reg_wr = 1;
    @(negedge clk);
    reg_wr = 0;
    @(negedge clk);
  endtask

  task automatic reg_read(logic [7:0] a, output logic [7:0] r);
    reg_addr = a;
    reg_rd = 1;
    @(negedge clk);
    reg_rd = 0;
    @(negedge clk);
    r = reg_rdata;
  endtask

  // Sends n words, zero on a channel when its flag is set
  task automatic send(int n, bit zl, bit zr);
    repeat (n)
    begin
      if (!in_ready) in_valid = 0;
      while (!in_ready) @(negedge clk);
      in_left = zl ? 24'h0 : (24'(xs()) | 24'h1);
      in_right = zr ? 24'h0 : (24'(xs()) | 24'h1);
      in_valid = 1;
      sq.push_back({in_left, in_right});
      sent++;
      @(negedge clk);
    end
    in_valid = 0;
    @(negedge clk);
    for (int i = 0; i < 500 && sample_sink_inst.got != sent; i++)
      @(negedge clk);
    repeat (3) @(negedge clk);
  endtask

  task automatic mute_is(logic [2:0] x);
    check(16'({am_both, am_left, am_right}), 16'(x));
  endtask

  initial
  begin
    repeat (20) @(negedge clk);
    rst = 0;
    @(negedge clk);
    for (int i = 0; i < 5; i++)
    begin
      reg_read(8'h4e + 8'(i), d);
      check(16'(d), 16'(rtab[i]));
    end
    for (int i = 0; i < 5; i++)
    begin
      e = 8'(xs());
      reg_write(8'h4e + 8'(i), e);
      reg_read(8'h4e + 8'(i), d);
      check(16'(d), (i < 4) ? 16'(e) : 16'h0000);
    end
    st = 8'hff;
    for (int i = 0; i < 8; i++)
    begin
      reg_write(tmg[i] ? ADDR_EMERG_RAMP : ADDR_NORMAL_RAMP, tcfg[i]);
      target_volume_code = ttgt[i];
      emergency_req = tmg[i];
      repeat (3) @(negedge clk);
      sample_sink_inst.q.delete();
      sq.delete();
      send(tn[i], 0, 0);
      for (int k = 1; k <= tn[i]; k++)
      begin
        e = expv(tcfg[i], tmg[i] ? 8'hff : ttgt[i], st, k);
        v = sample_sink_inst.q[k-1];
        check(v[15:0], {e, e});
        for (int j = 0; j < 3; j++)
          check(v[16+16*j +: 16], sq[k-1][16*j +: 16]);
      end
      d = tmg[i] ? 8'hff : ttgt[i];
      check(16'(ramp_busy), 16'(e != d));
      st = e;
    end
    reg_write(ADDR_ZERO_TIME, 8'h00);
    reg_write(ADDR_ZERO_CTL, 8'h03);
    send(10, 1, 0);
    mute_is(3'b000);
    send(1, 1, 0);
    mute_is(3'b010);
    reg_write(ADDR_ZERO_CTL, 8'h07);
    send(1, 1, 0);
    mute_is(3'b000);
    send(11, 1, 1);
    mute_is(3'b111);
    reg_write(ADDR_ZERO_CTL, 8'h06);
    send(1, 1, 1);
    mute_is(3'b001);
    send(1, 1, 0);
    mute_is(3'b000);
    reg_write(ADDR_ZERO_CTL, 8'h03);
    reg_write(ADDR_ZERO_TIME, 8'h10);
    send(1, 0, 0);
    send(52, 1, 1);
    mute_is(3'b001);
    send(1, 1, 1);
    mute_is(3'b111);
    results();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    results();
  end
endmodule // volume_ramp_auto_mute_bench
